/* ucrm_pkg.sv */
// Package of offsets, field positions and reset values for the channel register map
package ucrm_pkg;
  // ****************************************
  // Register indices on the four address lines
  // ****************************************
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_IER = 4'h1;
  localparam logic [3:0] ADDR_ISR = 4'h2;
  localparam logic [3:0] ADDR_LCR = 4'h3;
  localparam logic [3:0] ADDR_MCR = 4'h4;
  localparam logic [3:0] ADDR_LSR = 4'h5;
  localparam logic [3:0] ADDR_MSR = 4'h6;
  localparam logic [3:0] ADDR_SPR = 4'h7;
  localparam logic [3:0] ADDR_FEAT = 4'h8;
  localparam logic [3:0] ADDR_EFN = 4'h9;
  localparam logic [3:0] ADDR_RSVA = 4'hA;
  localparam logic [3:0] ADDR_RSVB = 4'hB;
  localparam logic [3:0] ADDR_STOP1 = 4'hC;
  localparam logic [3:0] ADDR_STOP2 = 4'hD;
  localparam logic [3:0] ADDR_RES1 = 4'hE;
  localparam logic [3:0] ADDR_RES2 = 4'hF;
  // ****************************************
  // Field positions and masks
  // ****************************************
  localparam int LCR_DLAB_BIT = 7;
  localparam int EFN_ENH_BIT = 4;
  localparam int MCR_LOOP_BIT = 4;
  localparam int MCR_OUT1_BIT = 2;
  localparam int MCR_OUT2_BIT = 3;
  localparam logic [7:0] IER_ENH_MASK = 8'hE0;
  localparam logic [7:0] ISR_ENH_MASK = 8'h30;
  localparam logic [7:0] FCR_ENH_MASK = 8'h30;
  localparam logic [7:0] MCR_ENH_MASK = 8'hEC;
  localparam logic [7:0] DLD_MASK = 8'h0F;
  localparam logic [7:0] FEAT_MASK = 8'h30;
  localparam logic [7:0] IER_MASK = 8'hEF;
  localparam logic [7:0] FLAG_MASK = 8'h0F;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h01;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
endpackage

/* ucrm_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module ucrm_fifo
  import ucrm_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [AW:0] count, next_count;
  logic doWr, doRd;

  assign inReady = (count != DEPTH[AW:0]);
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;

  always_comb
  begin
    next_wrPtr = doWr ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = doRd ? rdPtr + 1'b1 : rdPtr;
    next_count = count;
    if (doWr && !doRd)
      next_count = count + 1'b1;
    else if (doRd && !doWr)
      next_count = count - 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (doWr)
      mem[wrPtr] <= inData;
  end
endmodule
`default_nettype wire

/* ucrm_loopback.sv */
// Modem status source select between pins and internal loopback
`timescale 1ns/100ps
`default_nettype none
module ucrm_loopback
  import ucrm_pkg::*;
(
  input wire logic loopEn,
  input wire logic [3:0] pinStatus,
  input wire logic [7:0] modemControl,
  output logic [3:0] liveStatus
);
  // Order: cd, ri, dsr, cts. Pinless outputs feed back only here
  always_comb
  begin
    if (loopEn)
      liveStatus = {modemControl[MCR_OUT2_BIT], modemControl[MCR_OUT1_BIT],
        modemControl[0], modemControl[1]};
    else
      liveStatus = pinStatus;
  end
endmodule
`default_nettype wire

/* ucrm_channel.sv */
// Per-channel register map of the UART
`timescale 1ns/100ps
`default_nettype none
module ucrm_channel
  import ucrm_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  output logic txValid,
  input wire logic txReady,
  output logic [7:0] txData,
  output logic hostTxReady,
  input wire logic [7:0] rxByte,
  input wire logic [7:0] lineStatus,
  input wire logic [3:0] isrSource,
  input wire logic [3:0] flagEvents,
  input wire logic [3:0] modemPins,
  output logic [7:0] interrupt_enable_reg,
  output logic [7:0] fifo_control_reg,
  output logic fifoControlWr,
  output logic [7:0] line_control_reg,
  output logic [7:0] modem_control_reg,
  output logic [7:0] rs485DelayControl,
  output logic [7:0] featureControl,
  output logic [7:0] enhanced_function_reg,
  output logic [15:0] divisor,
  output logic [3:0] divisor_fraction,
  output logic [7:0] stopCharOne,
  output logic [7:0] stopCharTwo,
  output logic [7:0] resumeCharOne,
  output logic [7:0] resumeCharTwo,
  output logic dtrPin,
  output logic rtsPin
);
  // ****************************************
  // Decode
  // ****************************************
  logic enh, dlab, loopEn;
  logic [7:0] divLow, divHigh, scratch, flags, rdMux;
  logic [7:0] next_ier, next_fcr, next_lcr, next_mcr, next_msrw, next_feat, next_efn;
  logic [7:0] next_divLow, next_divHigh, next_scratch, next_flags, next_rdData;
  logic [7:0] next_s1, next_s2, next_r1, next_r2;
  logic [3:0] next_dld, modemLive, modemPrev, next_modemPrev, deltas, next_deltas;
  logic next_fcw, wrData0, fifoInReady;

  assign enh = enhanced_function_reg[EFN_ENH_BIT];
  assign dlab = line_control_reg[LCR_DLAB_BIT];
  assign loopEn = modem_control_reg[MCR_LOOP_BIT];
  assign divisor = {divHigh, divLow};
  assign wrData0 = wrStrobe && (regAddr == ADDR_DATA) && !dlab;
  assign hostTxReady = fifoInReady;
  // Pins are held inactive in loopback, as the legacy part does
  assign dtrPin = loopEn ? 1'b0 : modem_control_reg[0];
  assign rtsPin = loopEn ? 1'b0 : modem_control_reg[1];

  ucrm_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) txFifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .inValid(wrData0),
    .inReady(fifoInReady),
    .inData(wrData),
    .outValid(txValid),
    .outReady(txReady),
    .outData(txData)
  );

  ucrm_loopback loopSel (
    .loopEn(loopEn),
    .pinStatus(modemPins),
    .modemControl(modem_control_reg),
    .liveStatus(modemLive)
  );

  // ****************************************
  // Register writes
  // ****************************************
  always_comb
  begin
    next_ier = interrupt_enable_reg;
    next_fcr = fifo_control_reg;
    next_fcw = 1'b0;
    next_lcr = line_control_reg;
    next_mcr = modem_control_reg;
    next_msrw = rs485DelayControl;
    next_feat = featureControl;
    next_efn = enhanced_function_reg;
    next_divLow = divLow;
    next_divHigh = divHigh;
    next_dld = divisor_fraction;
    next_scratch = scratch;
    next_s1 = stopCharOne;
    next_s2 = stopCharTwo;
    next_r1 = resumeCharOne;
    next_r2 = resumeCharTwo;
    if (wrStrobe)
    begin
      if (regAddr == ADDR_DATA && dlab)
        next_divLow = wrData;
      else if (regAddr == ADDR_IER && dlab)
        next_divHigh = wrData;
      else if (regAddr == ADDR_IER)
        next_ier = (wrData & IER_MASK & ~IER_ENH_MASK)
          | (enh ? (wrData & IER_ENH_MASK) : (interrupt_enable_reg & IER_ENH_MASK));
      else if (regAddr == ADDR_ISR && dlab)
        next_dld = wrData[3:0];
      else if (regAddr == ADDR_ISR)
      begin
        next_fcr = (wrData & ~FCR_ENH_MASK)
          | (enh ? (wrData & FCR_ENH_MASK) : (fifo_control_reg & FCR_ENH_MASK));
        next_fcw = 1'b1;
      end
      else if (regAddr == ADDR_LCR)
        next_lcr = wrData;
      else if (regAddr == ADDR_MCR)
        next_mcr = (wrData & ~MCR_ENH_MASK)
          | (enh ? (wrData & MCR_ENH_MASK) : (modem_control_reg & MCR_ENH_MASK));
      else if (regAddr == ADDR_MSR && enh)
        next_msrw = wrData;
      else if (regAddr == ADDR_SPR)
        next_scratch = wrData;
      else if (regAddr == ADDR_FEAT)
        next_feat = wrData & FEAT_MASK;
      else if (regAddr == ADDR_EFN)
        next_efn = wrData;
      else if (regAddr == ADDR_STOP1)
        next_s1 = wrData;
      else if (regAddr == ADDR_STOP2)
        next_s2 = wrData;
      else if (regAddr == ADDR_RES1)
        next_r1 = wrData;
      else if (regAddr == ADDR_RES2)
        next_r2 = wrData;
    end
    // Dropping the enable clears the upper enable bits so they stay inert
    if (!next_efn[EFN_ENH_BIT])
      next_ier = next_ier & ~IER_ENH_MASK;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      interrupt_enable_reg <= RST_BYTE;
      fifo_control_reg <= RST_BYTE;
      fifoControlWr <= 1'b0;
      line_control_reg <= RST_BYTE;
      modem_control_reg <= RST_BYTE;
      rs485DelayControl <= RST_BYTE;
      featureControl <= RST_BYTE;
      enhanced_function_reg <= RST_BYTE;
      divLow <= DIV_RESET;
      divHigh <= RST_BYTE;
      divisor_fraction <= 4'h0;
      scratch <= RST_BYTE;
      stopCharOne <= RST_BYTE;
      stopCharTwo <= RST_BYTE;
      resumeCharOne <= RST_BYTE;
      resumeCharTwo <= RST_BYTE;
    end
    else
    begin
      interrupt_enable_reg <= next_ier;
      fifo_control_reg <= next_fcr;
      fifoControlWr <= next_fcw;
      line_control_reg <= next_lcr;
      modem_control_reg <= next_mcr;
      rs485DelayControl <= next_msrw;
      featureControl <= next_feat;
      enhanced_function_reg <= next_efn;
      divLow <= next_divLow;
      divHigh <= next_divHigh;
      divisor_fraction <= next_dld;
      scratch <= next_scratch;
      stopCharOne <= next_s1;
      stopCharTwo <= next_s2;
      resumeCharOne <= next_r1;
      resumeCharTwo <= next_r2;
    end
  end

  // ****************************************
  // Status flags and read path
  // ****************************************
  always_comb
  begin
    next_modemPrev = modemLive;
    next_deltas = deltas | (modemLive ^ modemPrev);
    next_flags = flags | {4'h0, flagEvents};
    // Set wins over the read-clear: the new event is or-ed in after clearing
    if (rdStrobe && regAddr == ADDR_MSR)
      next_deltas = modemLive ^ modemPrev;
    if (rdStrobe && regAddr == ADDR_STOP1)
      next_flags = {4'h0, flagEvents} & FLAG_MASK;
  end

  always_comb
  begin
    rdMux = RST_BYTE;
    if (regAddr == ADDR_DATA)
      rdMux = dlab ? divLow : rxByte;
    else if (regAddr == ADDR_IER)
      rdMux = dlab ? divHigh
        : (interrupt_enable_reg & (enh ? IER_MASK : (IER_MASK & ~IER_ENH_MASK)));
    else if (regAddr == ADDR_ISR)
      rdMux = dlab ? ({4'h0, divisor_fraction} & DLD_MASK)
        : ({{2{fifo_control_reg[0]}}, 2'b00, isrSource}
          | ({2'b00, isrSource[3:0] == 4'h0 ? 2'b00 : 2'b00, 4'h0})
          | (enh ? ({2'b00, flagEvents[1:0] != 2'b00, flags[1:0] != 2'b00, 4'h0}
            & ISR_ENH_MASK) : RST_BYTE));
    else if (regAddr == ADDR_LCR)
      rdMux = line_control_reg;
    else if (regAddr == ADDR_MCR)
      rdMux = modem_control_reg;
    else if (regAddr == ADDR_LSR)
      rdMux = lineStatus;
    else if (regAddr == ADDR_MSR)
      rdMux = {modemLive, deltas};
    else if (regAddr == ADDR_SPR)
      rdMux = scratch;
    else if (regAddr == ADDR_FEAT)
      rdMux = featureControl;
    else if (regAddr == ADDR_EFN)
      rdMux = enhanced_function_reg;
    else if (regAddr == ADDR_STOP1)
      rdMux = flags & FLAG_MASK;
    next_rdData = rdStrobe ? rdMux : rdData;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      modemPrev <= 4'h0;
      deltas <= 4'h0;
      flags <= RST_BYTE;
      rdData <= RST_BYTE;
    end
    else
    begin
      modemPrev <= next_modemPrev;
      deltas <= next_deltas;
      flags <= next_flags;
      rdData <= next_rdData;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_ier_gate;
    @(posedge core_clk) disable iff (sys_rst)
    !enh |-> (interrupt_enable_reg & IER_ENH_MASK) == 8'h00;
  endproperty
  a_ier_gate: assert property (p_ier_gate) else $error("upper enables set while gated");

  property p_fcr_hold;
    @(posedge core_clk) disable iff (sys_rst)
    (wrStrobe && regAddr == ADDR_ISR && !dlab && !enh)
      |=> (fifo_control_reg & FCR_ENH_MASK) == ($past(fifo_control_reg) & FCR_ENH_MASK);
  endproperty
  a_fcr_hold: assert property (p_fcr_hold) else $error("fifo trigger written while gated");

  property p_mcr_hold;
    @(posedge core_clk) disable iff (sys_rst)
    (wrStrobe && regAddr == ADDR_MCR && !enh)
      |=> (modem_control_reg & MCR_ENH_MASK) == ($past(modem_control_reg) & MCR_ENH_MASK);
  endproperty
  a_mcr_hold: assert property (p_mcr_hold) else $error("modem extended bits written while gated");

  property p_msrw_hold;
    @(posedge core_clk) disable iff (sys_rst)
    (wrStrobe && regAddr == ADDR_MSR && !enh) |=> $stable(rs485DelayControl);
  endproperty
  a_msrw_hold: assert property (p_msrw_hold) else $error("delay control written while gated");

  property p_loop_route;
    @(posedge core_clk) disable iff (sys_rst)
    (rdStrobe && regAddr == ADDR_MSR && loopEn)
      |=> rdData[7:6] == $past({modem_control_reg[MCR_OUT2_BIT], modem_control_reg[MCR_OUT1_BIT]});
  endproperty
  a_loop_route: assert property (p_loop_route) else $error("loopback not routed");

  property p_pins_free;
    @(posedge core_clk) disable iff (sys_rst)
    (!loopEn && $stable(loopEn) && $changed(modem_control_reg[3:2])
      && $stable(modem_control_reg[1:0]))
      |-> $stable(dtrPin) && $stable(rtsPin);
  endproperty
  a_pins_free: assert property (p_pins_free) else $error("pin follows output bits");

  property p_div_write;
    @(posedge core_clk) disable iff (sys_rst)
    (wrStrobe && regAddr == ADDR_DATA && dlab) |=> divisor[7:0] == $past(wrData) && !$past(wrData0);
  endproperty
  a_div_write: assert property (p_div_write) else $error("divisor low not written");

  property p_scratch;
    @(posedge core_clk) disable iff (sys_rst)
    (wrStrobe && regAddr == ADDR_SPR) ##1 (rdStrobe && regAddr == ADDR_SPR && !wrStrobe)
      |=> rdData == $past(wrData, 2);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch readback wrong");

  property p_enh_read;
    @(posedge core_clk) disable iff (sys_rst)
    (rdStrobe && !enh && regAddr == ADDR_ISR && !dlab) |=> rdData[5:4] == 2'b00;
  endproperty
  a_enh_read: assert property (p_enh_read) else $error("status extension visible");

  c_fifo_full: cover property (@(posedge core_clk) !fifoInReady);
  c_loop: cover property (@(posedge core_clk) loopEn && rdStrobe && regAddr == ADDR_MSR);
  c_enh: cover property (@(posedge core_clk) enh ##1 !enh);
endmodule
`default_nettype wire

/* ucrm_serial_model.sv */
// Serial engine stand-in on the far side of the channel register map
`timescale 1ns/100ps
`default_nettype none
module ucrm_serial_model
  import ucrm_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic flagReq,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  output logic [7:0] rxByte,
  output logic [7:0] lineStatus,
  output logic [3:0] isrSource,
  output logic [3:0] flagEvents,
  output logic [3:0] modemPins,
  output int rxCount
);
  logic [7:0] rxLog [16];
  // ****************************************
  // Engine levels and events
  // ****************************************
  // Stall lets the bench fill the transmit FIFO to its limit
  assign txReady = !stall;
  assign rxByte = 8'h5A;
  assign lineStatus = 8'h60;
  assign isrSource = 4'h1;
  // Idle pins low, so loopback values cannot be mistaken for pin values
  assign modemPins = 4'h0;
  assign flagEvents = flagReq ? 4'h5 : 4'h0;
  // ****************************************
  // Capture of transmitted bytes
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      rxCount <= 0;
    else if (txValid && txReady)
    begin
      rxLog[rxCount[3:0]] <= txData;
      rxCount <= rxCount + 1;
    end
  end
endmodule
`default_nettype wire

/* ucrm_testbench.sv */
// Self-checking testbench of the channel register map
`timescale 1ns/100ps
`default_nettype none
module testbench
  import ucrm_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic [7:0] wrData = 8'h00;
  logic stall = 1'b0;
  logic flagReq = 1'b0;
  logic [7:0] rdData, txData, rxByte, lineStatus, modem_control, fifo_control, rs485, enhanced_function, stop2;
  logic [3:0] isrSource, flagEvents, modemPins, frac;
  logic [15:0] divisor;
  logic txValid, txReady, hostTxReady, dtrPin, rtsPin;
  int rxCount;
  int numErrors = 0;
  int totalChecks = 0;
  ucrm_channel u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .wrData(wrData), .rdData(rdData),
    .txValid(txValid), .txReady(txReady), .txData(txData), .hostTxReady(hostTxReady),
    .rxByte(rxByte), .lineStatus(lineStatus), .isrSource(isrSource),
    .flagEvents(flagEvents), .modemPins(modemPins), .interrupt_enable_reg(),
    .fifo_control_reg(fifo_control), .fifoControlWr(), .line_control_reg(),
    .modem_control_reg(modem_control), .rs485DelayControl(rs485), .featureControl(),
    .enhanced_function_reg(enhanced_function), .divisor(divisor), .divisor_fraction(frac),
    .stopCharOne(), .stopCharTwo(stop2), .resumeCharOne(), .resumeCharTwo(),
    .dtrPin(dtrPin), .rtsPin(rtsPin));
  ucrm_serial_model u_model (.core_clk(core_clk), .sys_rst(sys_rst), .stall(stall),
    .flagReq(flagReq), .txValid(txValid), .txData(txData), .txReady(txReady),
    .rxByte(rxByte), .lineStatus(lineStatus), .isrSource(isrSource),
    .flagEvents(flagEvents), .modemPins(modemPins), .rxCount(rxCount));
  // ****************************************
  // Clock and bus tasks
  // ****************************************
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  task automatic endSim();
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    totalChecks++;
    if (g !== e)
    begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // One strobe cycle, then a spare edge so outputs have settled
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    wrData <= d;
    wrStrobe <= w;
    rdStrobe <= !w;
    @(posedge core_clk);
    wrStrobe <= 1'b0;
    rdStrobe <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input string n);
    acc(1'b0, a, 8'h00);
    chk(n, {8'h00, e}, {8'h00, rdData});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdchk(ADDR_LCR, 8'h00, "lcr reset");
    acc(1'b1, ADDR_SPR, 8'hA5);
    rdchk(ADDR_SPR, 8'hA5, "scratch");
    acc(1'b1, ADDR_LCR, 8'h80);
    rdchk(ADDR_DATA, 8'h01, "div low reset");
    acc(1'b1, ADDR_DATA, 8'h34);
    acc(1'b1, ADDR_IER, 8'h12);
    acc(1'b1, ADDR_ISR, 8'hFF);
    rdchk(ADDR_ISR, 8'h0F, "div fraction");
    chk("divisor", 16'h1234, divisor);
    chk("fraction", 16'h000F, {12'h000, frac});
    acc(1'b1, ADDR_LCR, 8'h03);
    rdchk(ADDR_DATA, 8'h5A, "rx holding");
    // Enhanced bit clear: gated fields inert
    acc(1'b1, ADDR_IER, 8'hFF);
    rdchk(ADDR_IER, 8'h0F, "ier gated");
    acc(1'b1, ADDR_MCR, 8'hFF);
    chk("mcr gated", 16'h0013, {8'h00, modem_control});
    acc(1'b1, ADDR_ISR, 8'hFF);
    chk("fcr gated", 16'h00CF, {8'h00, fifo_control});
    rdchk(ADDR_ISR, 8'hC1, "isr gated");
    acc(1'b1, ADDR_MSR, 8'hAB);
    chk("msr write gated", 16'h0000, {8'h00, rs485});
    acc(1'b0, ADDR_MSR, 8'h00);
    chk("loop status", 16'h0003, {12'h000, rdData[7:4]});
    // Enhanced bit set: extended fields reachable
    acc(1'b1, ADDR_EFN, 8'h10);
    chk("efn", 16'h0010, {8'h00, enhanced_function});
    acc(1'b1, ADDR_IER, 8'hFF);
    rdchk(ADDR_IER, 8'hEF, "ier enhanced");
    acc(1'b1, ADDR_MCR, 8'h1C);
    chk("mcr enhanced", 16'h001C, {8'h00, modem_control});
    acc(1'b0, ADDR_MSR, 8'h00);
    chk("loop outputs", 16'h000C, {12'h000, rdData[7:4]});
    acc(1'b1, ADDR_MCR, 8'h0C);
    chk("pins from outputs", 16'h0000, {14'h0000, dtrPin, rtsPin});
    acc(1'b1, ADDR_MCR, 8'h03);
    chk("pins driven", 16'h0003, {14'h0000, dtrPin, rtsPin});
    acc(1'b1, ADDR_ISR, 8'h30);
    chk("fcr enhanced", 16'h0030, {8'h00, fifo_control});
    acc(1'b1, ADDR_MSR, 8'hAB);
    chk("msr write", 16'h00AB, {8'h00, rs485});
    // Clearing the enhanced bit drops the extended enables again
    acc(1'b1, ADDR_EFN, 8'h00);
    rdchk(ADDR_IER, 8'h0F, "ier cleared");
    acc(1'b1, ADDR_MCR, 8'hF0);
    chk("mcr keeps old", 16'h0010, {8'h00, modem_control});
    acc(1'b1, ADDR_FEAT, 8'hFF);
    rdchk(ADDR_FEAT, 8'h30, "feature");
    // Reserved and write-only upper places read as zero
    for (int a = 10; a < 16; a++)
    begin
      if (a != 12)
      begin
        acc(1'b1, a[3:0], 8'hFF);
        rdchk(a[3:0], 8'h00, "upper read");
      end
    end
    chk("stop char two", 16'h00FF, {8'h00, stop2});
    @(posedge core_clk);
    flagReq <= 1'b1;
    @(posedge core_clk);
    flagReq <= 1'b0;
    rdchk(ADDR_STOP1, 8'h05, "flags");
    rdchk(ADDR_STOP1, 8'h00, "flags cleared");
    // Transmit FIFO filled past its depth while the engine stalls
    stall <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      if (i == 8)
        chk("fifo full", 16'h0000, {15'h0000, hostTxReady});
      acc(1'b1, ADDR_DATA, 8'h10 + i[7:0]);
    end
    stall <= 1'b0;
    for (int t = 0; t < 100 && rxCount < 8; t++)
      @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    chk("tx count", 16'h0008, rxCount[15:0]);
    for (int i = 0; i < 8; i++)
      chk("tx byte", {8'h00, 8'h10 + i[7:0]}, {8'h00, u_model.rxLog[i]});
    endSim();
  end
endmodule
`default_nettype wire
